/* File: verilog/rmc_map.svh */
/*
  Constants of the remote command parser: register offsets, field
  positions, reset values, code values, character codes and timing.
  Assumes inclusion by bare name from the package and the parser.
*/
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

`define RMC_CLOCK_HZ       40000000
`define RMC_COUNT_PERIOD_S 10
`define RMC_ROUTE_MAX      10

`define RMC_REG_CTRL       4'h0
`define RMC_REG_RCNT       4'h1
`define RMC_REG_ROUTE0     4'h2
`define RMC_REG_STATUS     4'hC
`define RMC_CTRL_TEXT_BIT  0
`define RMC_CTRL_DEST_LSB  8

`define RMC_CH_RESET       8'h01
`define RMC_DEST_RESET     8'h00
`define RMC_CH_MIN         8'h01
`define RMC_CH_MAX         8'h7F
`define RMC_ID_MAX         8'hFE
`define RMC_SIZE_VOL       8'h05
`define RMC_SIZE_NV        8'h07
`define RMC_ACK_SIZE       8'h05
`define RMC_ERR_HEX        8'h05
`define RMC_ERR_FMT        8'h06

`define RMC_A_STAR         8'h2A
`define RMC_A_EQ           8'h3D
`define RMC_A_CR           8'h0D
`define RMC_A_LF           8'h0A
`define RMC_A_SLASH        8'h2F
`define RMC_A_COMMA        8'h2C
`define RMC_A_SPACE        8'h20
`define RMC_A_AT           8'h40
`define RMC_A_C            8'h43
`define RMC_A_D            8'h44
`define RMC_A_E            8'h45
`define RMC_A_F            8'h46
`define RMC_A_H            8'h48
`define RMC_A_R            8'h52
`define RMC_A_T            8'h54
`define RMC_A_W            8'h57

`endif

/* File: verilog/rmc_pkg.sv */
/*
  Types of the remote command parser: states, reply kinds, radio
  request and radio event carriers.
  Assumes rmc_map.svh is on the include path.
*/
`include "rmc_map.svh"

package rmc_pkg;

  typedef enum logic [4:0] {
    P_IDLE = 5'h00, P_D  = 5'h01, P_T   = 5'h03, P_S1  = 5'h02,
    P_S2   = 5'h06, P_AT = 5'h07, P_C   = 5'h05, P_K   = 5'h04,
    P_V1   = 5'h0C, P_V2 = 5'h0D, P_SL  = 5'h0F, P_OPT = 5'h0E,
    P_RT   = 5'h0A, P_LF = 5'h0B, P_ERR = 5'h09
  } rmc_pstate_t;

  typedef enum logic [1:0] {
    R_EXT = 2'h0, R_ACK = 2'h1, R_LANE = 2'h3, R_ERR = 2'h2
  } rmc_rkind_t;

  typedef enum logic [1:0] {
    EV_NONE = 2'h0, EV_ACK = 2'h1, EV_LANE = 2'h3, EV_TEST = 2'h2
  } rmc_evt_kind_t;

  typedef struct packed {
    logic                             test;
    logic                             group;
    logic                             persist;
    logic [7:0]                       value;
    logic [3:0]                       hops;
    logic [7:0]                       target;
    logic [`RMC_ROUTE_MAX-1:0][7:0]   route;
  } rmc_rf_req_t;

  typedef struct packed {
    rmc_evt_kind_t kind;
    logic          ok;
    logic          persist;
    logic [7:0]    value;
  } rmc_rf_evt_t;

endpackage : rmc_pkg

/* File: verilog/rmc_remote_parser.sv */
/*
  Remote command parser of a radio modem: takes host command lines,
  checks the wrapped lane-change and remote-test commands, issues radio
  requests, answers the host, runs the timed test transmission.
  Assumes a radio layer that carries requests and reports events, a
  host byte stream with valid/ready, and a plain register port.
*/
`timescale 1ns/1ps
`include "rmc_map.svh"

// Notes on behaviour
// RULE_01 - lane value is two hex characters from 01h to 7Fh; others rejected
// RULE_02 - route is comma list of two-hex ids up to FEh, ten at most
// RULE_03 - use route given in line, else stored route, else destination id
// RULE_04 - with no route in the line and no stored route the destination id is the target
// RULE_05 - host puts the target station id last in any route it sends
// RULE_06 - persist option goes with size seven; volatile change uses five
// RULE_07 - single target: answer size at once, later ack echoing command
// RULE_08 - host should change distant stations first, then nearer ones
// RULE_09 - group switch: each station switches when its acknowledgement arrives
// RULE_10 - station missing the acknowledgement keeps its previous lane
// RULE_11 - after group switch source changes lane and reports the new value
// RULE_12 - remote test runs count times ten seconds, count 01h to FFh
// RULE_13 - test sends CR LF repeatedly; host input during test is sent
// RULE_14 - nothing arriving by radio stops a running test early
// RULE_15 - test completion gives ack of size 05 with test command and count
// RULE_16 - results from the target come back to the host as data receive
// RULE_17 - error reply is star, name, equals, code, CR LF
// RULE_18 - code-only mode by default; text mode adds colon and text
// RULE_19 - payload command format faults use codes 05 and 06
// RULE_20 - payload size must equal embedded command length, else fault
module rmc_remote_parser
  import rmc_pkg::*;
#(
  parameter int unsigned COUNT_CYCLES =
    `RMC_COUNT_PERIOD_S * `RMC_CLOCK_HZ
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        host_rx_valid,
  input  wire logic [7:0]  host_rx_byte,
  output logic             host_rx_ready,
  output logic             host_tx_valid,
  output logic [7:0]       host_tx_byte,
  input  wire logic        host_tx_ready,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             rf_req_valid,
  output rmc_rf_req_t      rf_req,
  input  wire rmc_rf_evt_t rf_evt,
  output logic             rf_tx_valid,
  output logic [7:0]       rf_tx_byte,
  input  wire logic        rf_tx_ready,
  output logic             test_active,
  output logic             test_done,
  output logic [7:0]       own_lane,
  output logic             nv_store
);

  localparam int RM = `RMC_ROUTE_MAX;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction : hex_val

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  // returns {last, character} of reply k at position i
  function automatic logic [8:0] reply_char(input rmc_rkind_t k,
      input logic [4:0] i, input logic [7:0] mid, input logic [7:0] val,
      input logic tst, input logic txt);
    logic [4:0] tail;
    logic [4:0] j;
    logic [7:0] ch;
    tail = (k == R_ACK) ? 5'h05 : ((k == R_ERR && txt) ? 5'h0E : 5'h00);
    j    = i - 5'h06;
    ch   = `RMC_A_LF;
    if (i == 5'h00) ch = `RMC_A_STAR;
    else if (i == 5'h01)
      ch = (k == R_ERR) ? `RMC_A_E : ((k == R_LANE) ? `RMC_A_C : `RMC_A_D);
    else if (i == 5'h02)
      ch = (k == R_EXT) ? `RMC_A_T : ((k == R_LANE) ? `RMC_A_H : `RMC_A_R);
    else if (i == 5'h03) ch = `RMC_A_EQ;
    else if (i == 5'h04) ch = hex_chr(mid[7:4]);
    else if (i == 5'h05) ch = hex_chr(mid[3:0]);
    else if (i < 5'h06 + tail) begin
      if (k == R_ACK) begin
        case (j)
          5'h00:   ch = `RMC_A_AT;
          5'h01:   ch = `RMC_A_C;
          5'h02:   ch = tst ? `RMC_A_T : `RMC_A_H;
          5'h03:   ch = hex_chr(val[7:4]);
          default: ch = hex_chr(val[3:0]);
        endcase
      end else begin
        case (j)
          5'h00:   ch = 8'h3A;
          5'h01:   ch = 8'h70;
          5'h02:   ch = 8'h61;
          5'h03:   ch = 8'h79;
          5'h04:   ch = 8'h6C;
          5'h05:   ch = 8'h6F;
          5'h06:   ch = 8'h61;
          5'h07:   ch = 8'h64;
          5'h08:   ch = 8'h20;
          5'h09:   ch = 8'h66;
          5'h0A:   ch = 8'h61;
          5'h0B:   ch = 8'h75;
          5'h0C:   ch = 8'h6C;
          default: ch = 8'h74;
        endcase
      end
    end else if (i == 5'h06 + tail) ch = `RMC_A_CR;
    return {i == 5'h07 + tail, ch};
  endfunction : reply_char

  rmc_pstate_t         st_q;
  logic [7:0]          size_q, val_q, err_q, em_mid_q;
  logic [3:0]          hi_q, rcnt_q, srcnt_q;
  logic                test_q, persist_q, group_q, half_q;
  logic                line_end_q, err_end_q, text_q;
  logic [7:0]          dest_q;
  logic [RM-1:0][7:0]  rline_q, sroute_q;
  logic                em_busy_q, pend_q, ack_q, ack_ok_q, crlf_q;
  rmc_rkind_t          em_kind_q;
  logic [4:0]          em_idx_q;
  logic [7:0]          test_left_q;
  logic [31:0]         tick_q;
  logic                fwd_v_q;
  logic [7:0]          fwd_q;

  wire logic [7:0] c     = host_rx_byte;
  wire logic       acc   = host_rx_valid & host_rx_ready & ~test_active;
  wire logic       facc  = host_rx_valid & host_rx_ready & test_active;
  wire logic [4:0] hv    = hex_val(c);
  wire logic [7:0] entry = {hi_q, hv[3:0]};
  wire logic [8:0] rc    = reply_char(em_kind_q, em_idx_q, em_mid_q, val_q,
                                      test_q, text_q);
  wire logic       tx_free = ~host_tx_valid | host_tx_ready;
  wire logic       rf_free = ~rf_tx_valid | rf_tx_ready;

  // host line parser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= P_IDLE;
      size_q <= 8'h00;
      val_q <= 8'h00;
      err_q <= 8'h00;
      hi_q <= 4'h0;
      rcnt_q <= 4'h0;
      test_q <= 1'b0;
      persist_q <= 1'b0;
      group_q <= 1'b0;
      half_q <= 1'b0;
      line_end_q <= 1'b0;
      err_end_q <= 1'b0;
      rline_q <= '0;
    end else begin
      line_end_q <= 1'b0;
      err_end_q <= 1'b0;
      if (acc && c == `RMC_A_LF && st_q != P_IDLE && st_q != P_LF) begin
        if (st_q != P_ERR) err_q <= `RMC_ERR_FMT; // RULE_19
        err_end_q <= 1'b1; // RULE_17
        st_q <= P_IDLE;
      end else if (acc && st_q == P_LF && c == `RMC_A_LF) begin
        line_end_q <= 1'b1;
        st_q <= P_IDLE;
      end else if (acc && c != `RMC_A_SPACE) begin
        st_q <= P_ERR;
        err_q <= `RMC_ERR_FMT; // RULE_19
        case (st_q)
          P_IDLE: st_q <= (c == `RMC_A_AT) ? P_D : P_IDLE;
          P_D:    if (c == `RMC_A_D) st_q <= P_T;
          P_T:    if (c == `RMC_A_T) st_q <= P_S1;
          P_S1, P_V1: begin
            hi_q <= hv[3:0];
            if (hv[4]) st_q <= (st_q == P_S1) ? P_S2 : P_V2;
            else err_q <= `RMC_ERR_HEX; // RULE_19
          end
          P_S2: begin
            size_q <= entry;
            if (hv[4]) st_q <= P_AT;
            else err_q <= `RMC_ERR_HEX;
          end
          P_AT:   if (c == `RMC_A_AT) st_q <= P_C;
          P_C:    if (c == `RMC_A_C) st_q <= P_K;
          P_K: begin
            test_q <= (c == `RMC_A_T);
            if (c == `RMC_A_H || c == `RMC_A_T) st_q <= P_V1;
          end
          P_V2: begin
            val_q <= entry;
            persist_q <= 1'b0;
            group_q <= 1'b0;
            half_q <= 1'b0;
            rcnt_q <= 4'h0;
            if (!hv[4]) err_q <= `RMC_ERR_HEX;
            else if (test_q ? (entry == 8'h00) // RULE_12
                     : (entry < `RMC_CH_MIN || entry > `RMC_CH_MAX)) // RULE_01
              err_q <= `RMC_ERR_HEX;
            else st_q <= P_SL;
          end
          P_SL:   if (c == `RMC_A_SLASH) st_q <= P_OPT;
          P_OPT: begin
            if (c == `RMC_A_W && !test_q && !persist_q) begin
              persist_q <= 1'b1; // RULE_06
              st_q <= P_SL;
            end else if (c == `RMC_A_C) st_q <= P_RT;
            else if (c == `RMC_A_F && !test_q) begin
              group_q <= 1'b1;
              st_q <= P_RT;
            end
          end
          P_RT: begin
            st_q <= P_RT;
            if (hv[4] && !half_q) begin
              hi_q <= hv[3:0];
              half_q <= 1'b1;
            end else if (hv[4]) begin
              half_q <= 1'b0;
              rcnt_q <= rcnt_q + 4'h1;
              if (rcnt_q < 4'(RM)) rline_q[rcnt_q] <= entry;
              if (entry > `RMC_ID_MAX) begin // RULE_02
                st_q <= P_ERR;
                err_q <= `RMC_ERR_HEX;
              end else if (rcnt_q == 4'(RM)) st_q <= P_ERR; // RULE_02
            end else if (c == `RMC_A_COMMA) begin
              if (half_q || rcnt_q == 4'h0) st_q <= P_ERR;
            end else if (c == `RMC_A_CR) begin
              if (!half_q && size_q == (persist_q ? `RMC_SIZE_NV
                                        : `RMC_SIZE_VOL)) // RULE_20 RULE_06
                st_q <= P_LF;
              else st_q <= P_ERR;
            end else st_q <= P_ERR;
          end
          P_LF:   st_q <= P_ERR;
          default: begin
            st_q <= P_ERR;
            err_q <= err_q;
          end
        endcase
      end
    end
  end

  // radio requests, replies to the host and the own lane
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      em_busy_q <= 1'b0;
      em_kind_q <= R_EXT;
      em_idx_q <= 5'h00;
      em_mid_q <= 8'h00;
      pend_q <= 1'b0;
      ack_q <= 1'b0;
      ack_ok_q <= 1'b0;
      host_tx_valid <= 1'b0;
      host_tx_byte <= 8'h00;
      rf_req_valid <= 1'b0;
      rf_req <= '0;
      own_lane <= `RMC_CH_RESET;
      nv_store <= 1'b0;
    end else begin
      rf_req_valid <= 1'b0;
      nv_store <= 1'b0;
      if (tx_free) begin
        host_tx_valid <= em_busy_q;
        host_tx_byte <= rc[7:0];
        if (em_busy_q) em_idx_q <= em_idx_q + 5'h01;
        if (em_busy_q && rc[8]) em_busy_q <= 1'b0;
      end
      if (rf_evt.kind == EV_ACK && pend_q) begin
        ack_q <= 1'b1;
        ack_ok_q <= rf_evt.ok;
        pend_q <= 1'b0;
      end
      if (rf_evt.kind == EV_LANE && rf_evt.ok) begin
        own_lane <= rf_evt.value; // RULE_09 RULE_10
        nv_store <= rf_evt.persist;
      end
      if (err_end_q) begin
        em_busy_q <= 1'b1;
        em_kind_q <= R_ERR; // RULE_18
        em_idx_q <= 5'h00;
        em_mid_q <= err_q;
      end else if (line_end_q) begin
        em_busy_q <= 1'b1;
        em_kind_q <= R_EXT; // RULE_07
        em_idx_q <= 5'h00;
        em_mid_q <= size_q;
        pend_q <= 1'b1;
        rf_req_valid <= 1'b1;
        rf_req.test <= test_q;
        rf_req.group <= group_q;
        rf_req.persist <= persist_q;
        rf_req.value <= val_q;
        if (rcnt_q != 4'h0) begin // RULE_03
          rf_req.hops <= rcnt_q;
          rf_req.route <= rline_q;
          rf_req.target <= rline_q[rcnt_q - 4'h1];
        end else if (srcnt_q != 4'h0) begin // RULE_03
          rf_req.hops <= srcnt_q;
          rf_req.route <= sroute_q;
          rf_req.target <= sroute_q[srcnt_q - 4'h1];
        end else begin
          rf_req.hops <= 4'h0; // RULE_04
          rf_req.route <= '0;
          rf_req.target <= dest_q;
        end
      end else if (ack_q && !em_busy_q) begin
        ack_q <= 1'b0;
        em_busy_q <= 1'b1;
        em_idx_q <= 5'h00;
        if (group_q) begin
          em_kind_q <= R_LANE; // RULE_11
          em_mid_q <= ack_ok_q ? val_q : own_lane; // RULE_10
          if (ack_ok_q) begin
            own_lane <= val_q; // RULE_09 RULE_11
            nv_store <= persist_q;
          end
        end else if (ack_ok_q) begin
          em_kind_q <= R_ACK; // RULE_07 RULE_15 RULE_16
          em_mid_q <= `RMC_ACK_SIZE;
        end else begin
          em_kind_q <= R_ERR;
          em_mid_q <= `RMC_ERR_FMT;
        end
      end
    end
  end

  // timed test transmission at the target
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      test_active <= 1'b0;
      test_left_q <= 8'h00;
      tick_q <= 32'h0;
      test_done <= 1'b0;
    end else begin
      test_done <= 1'b0;
      if (!test_active) begin
        if (rf_evt.kind == EV_TEST && rf_evt.value != 8'h00) begin
          test_active <= 1'b1;
          test_left_q <= rf_evt.value; // RULE_12
          tick_q <= 32'h0;
        end
      end else if (tick_q == COUNT_CYCLES - 1) begin // RULE_14
        tick_q <= 32'h0;
        test_left_q <= test_left_q - 8'h01;
        if (test_left_q == 8'h01) begin
          test_active <= 1'b0;
          test_done <= 1'b1;
        end
      end else tick_q <= tick_q + 32'h1;
    end
  end

  // radio byte stream: host input first, else CR LF filler
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rf_tx_valid <= 1'b0;
      rf_tx_byte <= 8'h00;
      crlf_q <= 1'b0;
      fwd_v_q <= 1'b0;
      fwd_q <= 8'h00;
      host_rx_ready <= 1'b0;
    end else begin
      if (facc) begin
        fwd_v_q <= 1'b1; // RULE_13
        fwd_q <= c;
      end
      if (rf_free) begin
        rf_tx_valid <= test_active;
        if (test_active && fwd_v_q) begin
          rf_tx_byte <= fwd_q; // RULE_13
          fwd_v_q <= facc;
        end else begin
          rf_tx_byte <= crlf_q ? `RMC_A_LF : `RMC_A_CR; // RULE_13
          if (test_active) crlf_q <= ~crlf_q;
        end
      end
      if (test_active) host_rx_ready <= ~fwd_v_q & ~facc;
      else host_rx_ready <= ~(line_end_q | err_end_q | em_busy_q | pend_q
                              | ack_q | (acc & c == `RMC_A_LF));
    end
  end

  // register port
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      text_q <= 1'b0;
      dest_q <= `RMC_DEST_RESET;
      srcnt_q <= 4'h0;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `RMC_REG_CTRL) begin
        text_q <= reg_wdata[`RMC_CTRL_TEXT_BIT]; // RULE_18
        dest_q <= reg_wdata[`RMC_CTRL_DEST_LSB +: 8];
      end else if (reg_wr && reg_addr == `RMC_REG_RCNT) begin
        srcnt_q <= (reg_wdata[3:0] > 4'(RM)) ? 4'(RM) : reg_wdata[3:0];
      end
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `RMC_REG_CTRL)
          reg_rdata <= {dest_q, 7'h00, text_q};
        else if (reg_addr == `RMC_REG_RCNT)
          reg_rdata <= {12'h000, srcnt_q};
        else if (reg_addr == `RMC_REG_STATUS)
          reg_rdata <= {5'h00, ack_q, pend_q, test_active, own_lane};
        else if (reg_addr >= `RMC_REG_ROUTE0 &&
                 reg_addr < `RMC_REG_ROUTE0 + 4'(RM))
          reg_rdata <= {8'h00, sroute_q[reg_addr - `RMC_REG_ROUTE0]};
      end
    end
  end

  // stored route entries
  for (genvar g = 0; g < RM; g++) begin : g_route
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) sroute_q[g] <= 8'h00;
      else if (reg_wr && reg_addr == `RMC_REG_ROUTE0 + 4'(g))
        sroute_q[g] <= reg_wdata[7:0];
    end
  end

endmodule : rmc_remote_parser

/* File: verification/rmc_remote_parser_monitor.sv */
/* Checker of the remote command parser, bound to its ports.
   Assumes rmc_pkg is compiled first. */
`timescale 1ns/1ps
module rmc_remote_parser_monitor
  import rmc_pkg::*;
#(
  parameter int unsigned COUNT_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        host_rx_valid,
  input wire logic [7:0]  host_rx_byte,
  input wire logic        host_rx_ready,
  input wire logic        host_tx_valid,
  input wire logic [7:0]  host_tx_byte,
  input wire logic        host_tx_ready,
  input wire logic        rf_req_valid,
  input wire rmc_rf_req_t rf_req,
  input wire rmc_rf_evt_t rf_evt,
  input wire logic        rf_tx_valid,
  input wire logic        rf_tx_ready,
  input wire logic        test_active,
  input wire logic        test_done,
  input wire logic [7:0]  own_lane,
  input wire logic        nv_store
);
  logic [31:0] run_q, len_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // active cycles of the current test and the length it must reach
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 32'h0;
      len_q <= 32'h0;
    end else if (!test_active && rf_evt.kind == EV_TEST) begin
      run_q <= 32'h0;
      len_q <= rf_evt.value * COUNT_CYCLES;
    end else if (test_active) begin
      run_q <= run_q + 32'h1;
    end
  end

  sequence s_line_end;
    host_rx_valid && host_rx_ready && host_rx_byte == 8'h0A && !test_active;
  endsequence
  sequence s_reply_head;
    host_tx_valid && host_tx_byte == 8'h2A;
  endsequence

  chk_reply_start: assert property (
    s_line_end |-> ##3 s_reply_head) else $error("reply late");
  chk_tx_hold: assert property (
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_byte))
    else $error("reply byte dropped");
  chk_lane_range: assert property (
    rf_req_valid && !rf_req.test |-> rf_req.value inside {[8'h01:8'h7F]})
    else $error("lane out of range");
  chk_route_len: assert property (
    rf_req_valid |-> rf_req.hops <= 4'hA && rf_req.target != 8'hFF)
    else $error("bad route");
  chk_lane_follow: assert property (
    rf_evt.kind == EV_LANE && rf_evt.ok |=> own_lane == $past(rf_evt.value)
    && nv_store == $past(rf_evt.persist)) else $error("lane not taken");
  chk_lane_keep: assert property (
    rf_evt.kind == EV_LANE && !rf_evt.ok |=> $stable(own_lane) && !nv_store)
    else $error("lane changed on failure");
  chk_test_start: assert property (
    !test_active && rf_evt.kind == EV_TEST && rf_evt.value != 8'h00
    |=> test_active) else $error("test not started");
  chk_test_len: assert property (
    $fell(test_active) |-> run_q == len_q) else $error("test length wrong");
  chk_test_hold: assert property (
    test_active && run_q + 32'h1 < len_q |=> test_active)
    else $error("test stopped early");
  chk_rf_gate: assert property (
    rf_tx_valid && $past(rf_tx_ready || !rf_tx_valid) |-> $past(test_active))
    else $error("stream outside test");
endmodule : rmc_remote_parser_monitor

bind rmc_remote_parser rmc_remote_parser_monitor #(
  .COUNT_CYCLES(COUNT_CYCLES)
) u_monitor (
  .clock, .reset_n, .host_rx_valid, .host_rx_byte, .host_rx_ready,
  .host_tx_valid, .host_tx_byte, .host_tx_ready, .rf_req_valid, .rf_req,
  .rf_evt, .rf_tx_valid, .rf_tx_ready, .test_active, .test_done,
  .own_lane, .nv_store
);

/* File: verification/rmc_host_model.sv */
/* Host side model: sends command lines and takes reply bytes.
   Assumes one clock; stall comes from the testbench. */
`timescale 1ns/1ps
module rmc_host_model (
  input  wire logic       clock,
  input  wire logic       stall,
  input  wire logic       host_rx_ready,
  output logic            host_rx_valid,
  output logic [7:0]      host_rx_byte,
  output logic            host_tx_ready
);
  initial begin
    host_rx_valid = 1'b0;
    host_rx_byte = 8'h00;
  end
  assign host_tx_ready = !stall;

  // each byte held until taken; a released line shows the inverse byte
  task automatic send_line(input string s, output bit ok);
    int n;
    ok = 1'b1;
    foreach (s[i]) begin
      host_rx_byte <= s[i];
      host_rx_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (!host_rx_ready && n < 4000);
      ok = ok && n < 4000;
    end
    host_rx_valid <= 1'b0;
    host_rx_byte <= ~host_rx_byte;
    @(posedge clock);
  endtask : send_line
endmodule : rmc_host_model

/* File: verification/testbench.sv */
/* Testbench of the remote command parser with queued expectations.
   Assumes the parser, its package, checker and host model. */
`timescale 1ns/1ps
module testbench;
  import rmc_pkg::*;
  localparam int unsigned CC = 20;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        stall = 1'b1, rf_tx_ready = 1'b0;
  logic        rd_d = 1'b0, saw_x = 1'b0;
  logic        host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready;
  logic        reg_wr, reg_rd, rf_req_valid, rf_tx_valid;
  logic        test_active, test_done, nv_store;
  logic [7:0]  host_rx_byte, host_tx_byte, rf_tx_byte, own_lane, lane;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [19:0] req_seen, txq[$], rqq[$], rgq[$];
  rmc_rf_req_t rf_req;
  rmc_rf_evt_t rf_evt;
  int          bad_count = 0, samples_checked = 0, n;
  bit          ok;
  string       ls;
  integer      seed = 32'h2C90C999;
  string       bad[7] = '{"@DT05@CH80/C\r\n", "@DT05@CH00/C\r\n",
    "@DT05@CHG1/C\r\n", "@DT07@CH10/C\r\n", "@DT05@CH10/W/C\r\n",
    "@DT05@CT00/C\r\n", "@DT05@CH10/C00,01,02,03,04,05,06,07,08,09,0A\r\n"};
  string       code[7] = '{"05", "05", "05", "06", "06", "05", "06"};

  rmc_remote_parser #(.COUNT_CYCLES(CC)) uut (
    .clock, .reset_n, .host_rx_valid, .host_rx_byte, .host_rx_ready,
    .host_tx_valid, .host_tx_byte, .host_tx_ready, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rf_req_valid, .rf_req, .rf_evt,
    .rf_tx_valid, .rf_tx_byte, .rf_tx_ready, .test_active, .test_done,
    .own_lane, .nv_store);
  rmc_host_model u_host (.clock, .stall, .host_rx_ready, .host_rx_valid,
    .host_rx_byte, .host_tx_ready);

  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    stall <= ($random(seed) & 3) == 0;
    rf_tx_ready <= ($random(seed) & 1) != 0;
  end

  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  assign req_seen = {1'b0, rf_req.test, rf_req.group, rf_req.persist,
                     rf_req.value, rf_req.target};
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d)
      check("reg_rdata", 20'(reg_rdata), rgq.pop_front());
    if (host_tx_valid && host_tx_ready)
      check("host_tx", 20'(host_tx_byte), txq.pop_front());
    if (rf_req_valid)
      check("rf_req", req_seen, rqq.pop_front());
    if (rf_tx_valid && rf_tx_ready && rf_tx_byte == 8'h58)
      saw_x <= 1'b1;
    else if (rf_tx_valid && rf_tx_ready)
      check("rf_tx", 20'(rf_tx_byte inside {8'h0D, 8'h0A}), 20'h1);
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rgq.push_back(20'(e));
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic drain(input string r);
    foreach (r[i]) txq.push_back(20'(r[i]));
    n = 0;
    while (txq.size() != 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (!ok || n >= 4000) begin
      bad_count++;
      end_of_test();
    end
  endtask : drain

  task automatic line(input string s, input string r);
    u_host.send_line(s, ok);
    drain(r);
  endtask : line

  task automatic evt(input rmc_rf_evt_t e, input string r);
    @(posedge clock);
    rf_evt <= e;
    @(posedge clock);
    rf_evt <= '0;
    drain(r);
  endtask : evt

  initial begin
    rf_evt = '0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(4'hC, 16'h0001);
    wr(4'h1, 16'h000F);
    rd(4'h1, 16'h000A);
    rd(4'hD, 16'h0000);
    wr(4'h0, 16'h4200);
    rd(4'h0, 16'h4200);
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0011);
    wr(4'h3, 16'h0033);
    rqq.push_back({4'h0, 8'h20, 8'h33});
    line("@DT05@CH20/C\r\n", "*DT=05\r\n");
    evt('{EV_ACK, 1'b0, 1'b0, 8'h20}, "*ER=06\r\n");
    wr(4'h1, 16'h0000);
    rqq.push_back({4'h0, 8'h0E, 8'h8F});
    line("@DT05@CH0E/C01,02,8F\r\n", "*DT=05\r\n");
    evt('{EV_ACK, 1'b1, 1'b0, 8'h0E}, "*DR=05@CH0E\r\n");
    lane = 8'(($random(seed) & 32'h7F) | 32'h1);
    ls = $sformatf("%02h", lane);
    ls = ls.toupper();
    rqq.push_back({4'h3, lane, 8'h42});
    line($sformatf("@DT07@CH%02H/W/F\r\n", lane), "*DT=07\r\n");
    evt('{EV_ACK, 1'b1, 1'b1, lane}, {"*CH=", ls, "\r\n"});
    check("own_lane", 20'(own_lane), 20'(lane));
    rqq.push_back({4'h2, 8'h05, 8'h42});
    line("@DT05@CH05/F\r\n", "*DT=05\r\n");
    evt('{EV_ACK, 1'b0, 1'b0, 8'h05}, {"*CH=", ls, "\r\n"});
    check("own_lane", 20'(own_lane), 20'(lane));
    foreach (bad[i]) line(bad[i], {"*ER=", code[i], "\r\n"});
    wr(4'h0, 16'h4201);
    line("@DT05@CH90/C\r\n", "*ER=05:payload fault\r\n");
    wr(4'h0, 16'h4200);
    rqq.push_back({4'h4, 8'h02, 8'h05});
    line("@DT05@CT02/C05\r\n", "*DT=05\r\n");
    evt('{EV_ACK, 1'b1, 1'b0, 8'h02}, "*DR=05@CT02\r\n");
    evt('{EV_TEST, 1'b1, 1'b0, 8'h02}, "");
    evt('{EV_TEST, 1'b1, 1'b0, 8'h05}, "");
    line("X", "");
    n = 0;
    while (!test_done && n < 300) begin
      @(posedge clock);
      n++;
    end
    check("test_done", 20'(n < 300), 20'h1);
    check("host_byte_sent", 20'(saw_x), 20'h1);
    evt('{EV_LANE, 1'b1, 1'b1, 8'h22}, "");
    evt('{EV_LANE, 1'b0, 1'b0, 8'h33}, "");
    check("own_lane", 20'(own_lane), 20'h22);
    check("queues", 20'(rqq.size() + txq.size()), 20'h0);
    end_of_test();
  end
endmodule : testbench
